// [src/veb_core.sv]
// VM-entry event blocking, preemption timer and long-mode handoff
`timescale 1ns/1ps
module veb_core (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic entry_in,
  input wire logic entry_vectoring_in,
  input wire logic entry_inject_nmi_in,
  input wire logic [veb_pkg::VEB_INTR_W-1:0] intr_state_in,
  input wire logic virtual_nmi_ctl_in,
  input wire logic nmi_exiting_ctl_in,
  input wire logic system_management_state_in,
  input wire logic timer_activate_ctl_in,
  input wire logic [veb_pkg::VEB_TIMER_W-1:0] timer_value_in,
  input wire veb_pkg::veb_activity_t entry_activity_in,
  input wire logic entry_debug_pend_in,
  input wire logic debug_delivered_in,
  input wire logic debug_other_exit_in,
  input wire logic instr_retire_in,
  input wire logic exception_in,
  input wire logic interrupt_return_in,
  input wire logic exit_in,
  input wire logic save_timer_ctl_in,
  input wire logic long_mode_active_flag_in,
  input wire logic entry_paging_on_flag_in,
  input wire logic entry_long_mode_guest_ctl_in,
  input wire logic entry_load_ext_ctl_in,
  input wire logic entry_long_mode_enable_flag_in,
  input wire logic host_long_mode_enable_flag_in,
  output logic guest_running_out,
  output logic interrupt_enable_shadow_out,
  output logic stack_load_shadow_out,
  output logic nmi_blocked_out,
  output logic virtual_nmi_blocked_out,
  output logic smi_blocked_out,
  output logic [veb_pkg::VEB_TIMER_W-1:0] timer_count_out,
  output logic timer_exit_req_out,
  output logic timer_save_we_out,
  output logic [veb_pkg::VEB_TIMER_W-1:0] timer_save_value_out,
  output logic long_mode_guest_ctl_we_out,
  output logic long_mode_guest_ctl_out,
  output logic long_mode_enable_flag_out
);
  import veb_pkg::*;

  // ****************************************
  // Guest sequencing
  // ****************************************
  veb_state_t state_reg;
  logic timer_on_reg;
  logic expired_reg;
  logic tick;
  logic entry_ok;
  logic [VEB_TIMER_W-1:0] count_reg;

  assign entry_ok = entry_in && (state_reg == VEB_ST_ROOT);

  // Pending debug exception is held off the timer exit until delivered
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_reg <= VEB_ST_ROOT;
    end else begin
      case (state_reg)
        VEB_ST_ROOT: begin
          if (entry_in) begin
            state_reg <= entry_debug_pend_in ? VEB_ST_DEBUG : VEB_ST_GUEST;
          end
        end
        VEB_ST_DEBUG: begin
          if (exit_in || debug_other_exit_in) begin
            state_reg <= VEB_ST_ROOT;
          end else if (debug_delivered_in) begin
            state_reg <= VEB_ST_GUEST;
          end
        end
        VEB_ST_GUEST: begin
          if (exit_in) begin
            state_reg <= VEB_ST_ROOT;
          end
        end
        default: begin
          state_reg <= VEB_ST_ROOT;
        end
      endcase
    end
  end
  assign guest_running_out = (state_reg != VEB_ST_ROOT);

  // ****************************************
  // Interrupt-enable and stack-load shadows
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      interrupt_enable_shadow_out <= 1'b0;
      stack_load_shadow_out <= 1'b0;
    end else if (entry_ok) begin
      interrupt_enable_shadow_out <= !entry_vectoring_in
        && intr_state_in[VEB_BIT_IE_SHADOW];
      stack_load_shadow_out <= !entry_vectoring_in
        && intr_state_in[VEB_BIT_SL_SHADOW];
    end else if (guest_running_out && (instr_retire_in || exception_in
        || (state_reg == VEB_ST_DEBUG && debug_delivered_in))) begin
      interrupt_enable_shadow_out <= 1'b0;
      stack_load_shadow_out <= 1'b0;
    end
  end

  // ****************************************
  // NMI and virtual-NMI blocking
  // ****************************************
  // Software keeps virtual NMIs off when NMI exiting is off; not rechecked here
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      nmi_blocked_out <= 1'b0;
      virtual_nmi_blocked_out <= 1'b0;
    end else if (entry_ok) begin
      nmi_blocked_out <= !virtual_nmi_ctl_in && intr_state_in[VEB_BIT_NMI];
      virtual_nmi_blocked_out <= virtual_nmi_ctl_in
        && (intr_state_in[VEB_BIT_NMI] || entry_inject_nmi_in);
    end else if (guest_running_out && interrupt_return_in) begin
      if (!nmi_exiting_ctl_in) begin
        nmi_blocked_out <= 1'b0;
      end
      virtual_nmi_blocked_out <= 1'b0;
    end
  end

  // ****************************************
  // SMI blocking
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      smi_blocked_out <= 1'b0;
    end else if (entry_ok && system_management_state_in) begin
      smi_blocked_out <= intr_state_in[VEB_BIT_SMI];
    end
  end

  // ****************************************
  // Preemption timer
  // ****************************************
  veb_tick_div #(
    .DIV(VEB_TICK_DIV)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .run_in(timer_on_reg && (state_reg == VEB_ST_GUEST) && !expired_reg),
    .tick_out(tick)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      count_reg <= VEB_TIMER_RST;
      timer_on_reg <= 1'b0;
    end else if (entry_ok) begin
      count_reg <= timer_value_in;
      timer_on_reg <= timer_activate_ctl_in;
    end else if (exit_in) begin
      timer_on_reg <= 1'b0;
    end else if (tick && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end
  assign timer_count_out = count_reg;

  // Zero load expires at once; a parked target never takes the exit
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      expired_reg <= 1'b0;
    end else if (entry_ok) begin
      expired_reg <= timer_activate_ctl_in && timer_value_in == '0;
    end else if (exit_in) begin
      expired_reg <= 1'b0;
    end else if (timer_on_reg && tick && count_reg == {{(VEB_TIMER_W-1){1'b0}}, 1'b1}) begin
      expired_reg <= 1'b1;
    end
  end

  // Asserted only in guest state, so after injection and any debug delivery
  assign timer_exit_req_out = expired_reg && timer_on_reg && (state_reg == VEB_ST_GUEST)
    && (entry_activity_in == VEB_ACT_ACTIVE || entry_activity_in == VEB_ACT_HLT);

  // ****************************************
  // Save-back at exit, long-mode handoff at exit and at entry
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      timer_save_we_out <= 1'b0;
      timer_save_value_out <= VEB_TIMER_RST;
      long_mode_guest_ctl_we_out <= 1'b0;
      long_mode_guest_ctl_out <= 1'b0;
    end else begin
      timer_save_we_out <= exit_in && guest_running_out && save_timer_ctl_in;
      if (exit_in && guest_running_out) begin
        timer_save_value_out <= expired_reg ? '0 : count_reg;
        long_mode_guest_ctl_out <= long_mode_active_flag_in;
      end
      long_mode_guest_ctl_we_out <= exit_in && guest_running_out;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      long_mode_enable_flag_out <= 1'b0;
    end else if (entry_ok) begin
      if (!entry_paging_on_flag_in && !entry_long_mode_guest_ctl_in && !entry_load_ext_ctl_in) begin
        long_mode_enable_flag_out <= host_long_mode_enable_flag_in;
      end else begin
        long_mode_enable_flag_out <= entry_long_mode_enable_flag_in;
      end
    end else if (!guest_running_out) begin
      long_mode_enable_flag_out <= host_long_mode_enable_flag_in;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_vec_no_shadow;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && entry_vectoring_in |=> !interrupt_enable_shadow_out && !stack_load_shadow_out;
  endproperty
  a_vec_no_shadow: assert property (p_vec_no_shadow) else $error("shadow after vectoring");

  property p_ie_shadow;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && !entry_vectoring_in |=>
      interrupt_enable_shadow_out == $past(intr_state_in[VEB_BIT_IE_SHADOW]);
  endproperty
  a_ie_shadow: assert property (p_ie_shadow) else $error("ie shadow mismatch");

  property p_sl_shadow;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && !entry_vectoring_in |=>
      stack_load_shadow_out == $past(intr_state_in[VEB_BIT_SL_SHADOW]);
  endproperty
  a_sl_shadow: assert property (p_sl_shadow) else $error("sl shadow mismatch");

  property p_shadow_clear;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    guest_running_out && !entry_in && (instr_retire_in || exception_in) |=>
      !interrupt_enable_shadow_out && !stack_load_shadow_out;
  endproperty
  a_shadow_clear: assert property (p_shadow_clear) else $error("shadow not cleared");

  property p_vnmi_nmi;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && virtual_nmi_ctl_in |=> !nmi_blocked_out;
  endproperty
  a_vnmi_nmi: assert property (p_vnmi_nmi) else $error("nmi blocked under vnmi");

  property p_interrupt_return_vnmi;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    guest_running_out && !entry_in && interrupt_return_in |=> !virtual_nmi_blocked_out;
  endproperty
  a_interrupt_return_vnmi: assert property (p_interrupt_return_vnmi) else $error("vnmi kept after return");

  property p_smi_keep;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && !system_management_state_in |=> $stable(smi_blocked_out);
  endproperty
  a_smi_keep: assert property (p_smi_keep) else $error("smi changed");

  property p_zero_save;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    exit_in && guest_running_out && expired_reg && save_timer_ctl_in |=>
      timer_save_we_out && timer_save_value_out == '0;
  endproperty
  a_zero_save: assert property (p_zero_save) else $error("expired exit saved nonzero");

  property p_no_save;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    !save_timer_ctl_in |=> !timer_save_we_out;
  endproperty
  a_no_save: assert property (p_no_save) else $error("timer saved while disabled");

  property p_nmi_bit;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && !virtual_nmi_ctl_in |=>
      nmi_blocked_out == $past(intr_state_in[VEB_BIT_NMI]);
  endproperty
  a_nmi_bit: assert property (p_nmi_bit) else $error("nmi blocking mismatch");

  property p_interrupt_return_nmi;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    guest_running_out && interrupt_return_in |=>
      nmi_blocked_out == ($past(nmi_blocked_out) && $past(nmi_exiting_ctl_in));
  endproperty
  a_interrupt_return_nmi: assert property (p_interrupt_return_nmi) else $error("nmi after return wrong");

  property p_vnmi_set;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && virtual_nmi_ctl_in |=>
      virtual_nmi_blocked_out == ($past(intr_state_in[VEB_BIT_NMI])
        || $past(entry_inject_nmi_in));
  endproperty
  a_vnmi_set: assert property (p_vnmi_set) else $error("vnmi blocking mismatch");

  property p_smi_set;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && system_management_state_in |=>
      smi_blocked_out == $past(intr_state_in[VEB_BIT_SMI]);
  endproperty
  a_smi_set: assert property (p_smi_set) else $error("smi blocking mismatch");

  sequence s_zero_entry;
    entry_ok && timer_activate_ctl_in && timer_value_in == '0 && !entry_debug_pend_in
      && (entry_activity_in == VEB_ACT_ACTIVE || entry_activity_in == VEB_ACT_HLT);
  endsequence
  property p_zero_exit;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_zero_entry |=> timer_exit_req_out;
  endproperty
  a_zero_exit: assert property (p_zero_exit) else $error("no exit on zero load");

  property p_debug_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state_reg == VEB_ST_DEBUG |-> !timer_exit_req_out;
  endproperty
  a_debug_hold: assert property (p_debug_hold) else $error("exit before debug");

  sequence s_debug_done;
    state_reg == VEB_ST_DEBUG && debug_delivered_in && !exit_in && !debug_other_exit_in
      && expired_reg && timer_on_reg && entry_activity_in == VEB_ACT_ACTIVE;
  endsequence
  property p_dbg_exit;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_debug_done |=> timer_exit_req_out;
  endproperty
  a_dbg_exit: assert property (p_dbg_exit) else $error("no exit after debug");

  property p_count_save;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    exit_in && guest_running_out && save_timer_ctl_in && !expired_reg |=>
      timer_save_we_out && timer_save_value_out == $past(count_reg);
  endproperty
  a_count_save: assert property (p_count_save) else $error("saved count wrong");

  property p_lmg_copy;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    exit_in && guest_running_out |=> long_mode_guest_ctl_we_out
      && long_mode_guest_ctl_out == $past(long_mode_active_flag_in);
  endproperty
  a_lmg_copy: assert property (p_lmg_copy) else $error("long-mode guest not copied");

  property p_lme_keep;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    entry_ok && !entry_paging_on_flag_in && !entry_long_mode_guest_ctl_in
      && !entry_load_ext_ctl_in |=>
      long_mode_enable_flag_out == $past(host_long_mode_enable_flag_in);
  endproperty
  a_lme_keep: assert property (p_lme_keep) else $error("long-mode enable changed");

  property p_count_tick;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    tick && !exit_in && count_reg != '0 |=> count_reg == $past(count_reg) - 1'b1;
  endproperty
  a_count_tick: assert property (p_count_tick) else $error("timer did not count");
endmodule : veb_core

// [src/veb_pkg.sv]
// Package: constants and types of the VM-entry blocking and preemption timer block
package veb_pkg;
  localparam int unsigned VEB_TIMER_W = 32;
  localparam int unsigned VEB_INTR_W = 4;
  localparam int unsigned VEB_BIT_IE_SHADOW = 0;
  localparam int unsigned VEB_BIT_SL_SHADOW = 1;
  localparam int unsigned VEB_BIT_SMI = 2;
  localparam int unsigned VEB_BIT_NMI = 3;
  localparam int unsigned VEB_TICK_DIV = 32;
  localparam int unsigned VEB_TICK_CNT_W = 6;
  localparam logic [VEB_TIMER_W-1:0] VEB_TIMER_RST = 32'h0000_0000;
  typedef enum logic [1:0] {VEB_ACT_ACTIVE, VEB_ACT_HLT, VEB_ACT_SHUTDOWN, VEB_ACT_WAIT_SU}
    veb_activity_t;
  typedef enum {VEB_ST_ROOT, VEB_ST_DEBUG, VEB_ST_GUEST} veb_state_t;
endpackage : veb_pkg

// [src/veb_tick_div.sv]
// Divider that makes the timer decrement enable
`timescale 1ns/1ps
module veb_tick_div #(
  parameter int unsigned DIV = veb_pkg::VEB_TICK_DIV
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic run_in,
  output logic tick_out
);
  import veb_pkg::*;
  logic [VEB_TICK_CNT_W-1:0] cnt_reg;
  localparam logic [VEB_TICK_CNT_W-1:0] LAST = VEB_TICK_CNT_W'(DIV - 1);
  // Restarts with each run so every quantum begins on a full period
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || !run_in) begin
      cnt_reg <= '0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  assign tick_out = run_in && (cnt_reg == LAST);
endmodule : veb_tick_div

// [verif/tb_veb_core.sv]
// Self-checking testbench of the VM-entry blocking and preemption timer block
`timescale 1ns/1ps
module tb_veb_core;
  import veb_pkg::*;
  // ****************
  // Signals
  // ****************
  typedef struct {int sig; logic [31:0] lo; logic [31:0] hi;} veb_note_t;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, entry_in = 1'b0, vect = 1'b0, inj = 1'b0;
  logic [3:0] intr = 4'h0;
  logic vn = 1'b0, nx = 1'b0, system_management_state = 1'b0, act = 1'b0, dbg = 1'b0, dbg_done = 1'b0;
  logic [31:0] tval = 32'h0;
  veb_activity_t activity = VEB_ACT_ACTIVE;
  logic retire = 1'b0, exc = 1'b0, interrupt_return = 1'b0, exit_in = 1'b0, save = 1'b0, lma = 1'b0;
  logic pg = 1'b0, lmg = 1'b0, lext = 1'b0, elme = 1'b0, hlme = 1'b0;
  logic o_run, o_ies, o_sls, o_nmi, o_vnmi, o_smi, o_req, o_swe, o_lwe, o_lmg, o_lme;
  logic [31:0] o_cnt, o_sval, v, wait_cyc;
  int n_mismatch = 0, tests_run = 0, n;
  logic smi_m = 1'b0;
  logic [31:0] r;
  veb_note_t exp_q[$];
  veb_note_t e;
  string nm[14] = '{"running", "ie_shadow", "sl_shadow", "nmi_blk", "vnmi_blk", "smi_blk",
    "count", "exit_req", "save_we", "save_val", "lmg_we", "lmg", "lme", "wait_cycles"};

  always #5 clk_sys_in = ~clk_sys_in;

  veb_core i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .entry_in(entry_in),
    .entry_vectoring_in(vect), .entry_inject_nmi_in(inj), .intr_state_in(intr),
    .virtual_nmi_ctl_in(vn), .nmi_exiting_ctl_in(nx), .system_management_state_in(system_management_state),
    .timer_activate_ctl_in(act), .timer_value_in(tval), .entry_activity_in(activity),
    .entry_debug_pend_in(dbg), .debug_delivered_in(dbg_done), .debug_other_exit_in(1'b0),
    .instr_retire_in(retire), .exception_in(exc), .interrupt_return_in(interrupt_return),
    .exit_in(exit_in), .save_timer_ctl_in(save), .long_mode_active_flag_in(lma),
    .entry_paging_on_flag_in(pg), .entry_long_mode_guest_ctl_in(lmg),
    .entry_load_ext_ctl_in(lext), .entry_long_mode_enable_flag_in(elme),
    .host_long_mode_enable_flag_in(hlme), .guest_running_out(o_run),
    .interrupt_enable_shadow_out(o_ies), .stack_load_shadow_out(o_sls),
    .nmi_blocked_out(o_nmi), .virtual_nmi_blocked_out(o_vnmi), .smi_blocked_out(o_smi),
    .timer_count_out(o_cnt), .timer_exit_req_out(o_req), .timer_save_we_out(o_swe),
    .timer_save_value_out(o_sval), .long_mode_guest_ctl_we_out(o_lwe),
    .long_mode_guest_ctl_out(o_lmg), .long_mode_enable_flag_out(o_lme));

  // ****************
  // Tasks
  // ****************
  task step();
    @(posedge clk_sys_in);
  endtask : step

  task note(input int s, input logic [31:0] lo, input logic [31:0] hi);
    exp_q.push_back('{s, lo, hi});
  endtask : note

  // Entry pulse; returns at the settled point of the cycle after it
  task do_entry();
    entry_in <= 1'b1;
    step();
    entry_in <= 1'b0;
    @(negedge clk_sys_in);
  endtask : do_entry

  task do_exit(input logic sv, input logic [31:0] lo, input logic [31:0] hi);
    exit_in <= 1'b1;
    save <= sv;
    lma <= r[5];
    step();
    exit_in <= 1'b0;
    @(negedge clk_sys_in);
    note(8, sv, sv);
    if (sv) note(9, lo, hi);
    note(10, 1, 1);
    note(11, r[5], r[5]);
    note(0, 0, 0);
    step();
  endtask : do_exit

  task report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ****************
  // Monitor: every queued note, oldest first, against the settled outputs
  // ****************
  always begin
    @(negedge clk_sys_in);
    #1;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      case (e.sig)
        0: v = {31'h0, o_run};
        1: v = {31'h0, o_ies};
        2: v = {31'h0, o_sls};
        3: v = {31'h0, o_nmi};
        4: v = {31'h0, o_vnmi};
        5: v = {31'h0, o_smi};
        6: v = o_cnt;
        7: v = {31'h0, o_req};
        8: v = {31'h0, o_swe};
        9: v = o_sval;
        10: v = {31'h0, o_lwe};
        11: v = {31'h0, o_lmg};
        12: v = {31'h0, o_lme};
        default: v = wait_cyc;
      endcase
      tests_run++;
      if ((e.lo == e.hi) ? (v !== e.lo) : (((v >= e.lo) && (v <= e.hi)) !== 1'b1)) begin
        n_mismatch++;
        $display("BAD %s expected %0d..%0d seen %0d", nm[e.sig], e.lo, e.hi, v);
      end
    end
  end

  // The tests take about five hundred cycles; twenty thousand means a hang
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(46));
    repeat (4) step();
    rstn_in <= 1'b1;
    @(negedge clk_sys_in);
    for (int s = 0; s < 13; s++) note(s, 0, 0);
    step();
    // Blocking from every interruptibility pattern, then one clearing event
    for (int i = 0; i < 48; i++) begin
      r = $urandom;
      vect <= r[0];
      vn <= r[1];
      nx <= r[1] | r[2];
      system_management_state <= r[3];
      inj <= r[4] & r[0];
      intr <= i[3:0];
      do_entry();
      if (r[3]) smi_m = i[2];
      note(1, !r[0] & i[0], !r[0] & i[0]);
      note(2, !r[0] & i[1], !r[0] & i[1]);
      note(3, !r[1] & i[3], !r[1] & i[3]);
      note(4, r[1] & (i[3] | r[0] & r[4]), r[1] & (i[3] | r[0] & r[4]));
      note(5, smi_m, smi_m);
      note(7, 0, 0);
      step();
      retire <= !r[6];
      exc <= r[6];
      interrupt_return <= r[7];
      step();
      retire <= 1'b0;
      exc <= 1'b0;
      interrupt_return <= 1'b0;
      @(negedge clk_sys_in);
      note(1, 0, 0);
      note(2, 0, 0);
      n = !r[1] & i[3] & !(r[7] & !(r[1] | r[2]));
      note(3, n, n);
      n = r[1] & (i[3] | r[0] & r[4]) & !r[7];
      note(4, n, n);
      step();
      do_exit(0, 0, 0);
    end
    // Zero load takes the exit at entry unless the target is in shutdown or wait-for-SIPI
    act <= 1'b1;
    tval <= 32'h0;
    vect <= 1'b0;
    inj <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      activity <= veb_activity_t'(a);
      do_entry();
      note(7, a < 2, a < 2);
      step();
      do_exit(1, 0, 0);
    end
    // Pending debug exception goes first, then the timer exit
    activity <= VEB_ACT_ACTIVE;
    dbg <= 1'b1;
    intr <= 4'h1;
    do_entry();
    note(7, 0, 0);
    note(1, 1, 1);
    step();
    dbg <= 1'b0;
    dbg_done <= 1'b1;
    step();
    dbg_done <= 1'b0;
    @(negedge clk_sys_in);
    note(7, 1, 1);
    note(1, 0, 0);
    step();
    do_exit(1, 0, 0);
    // Countdown from a small load to the exit request
    n = 2 + $urandom % 3;
    tval <= n;
    do_entry();
    note(6, n, n);
    wait_cyc = 0;
    // Polled on the falling edge, where the request has settled
    while (o_req !== 1'b1 && wait_cyc < (n + 2) * VEB_TICK_DIV) begin
      @(negedge clk_sys_in);
      wait_cyc++;
    end
    @(negedge clk_sys_in);
    note(7, 1, 1);
    note(13, n * VEB_TICK_DIV, n * VEB_TICK_DIV);
    note(6, 0, 0);
    step();
    do_exit(1, 0, 0);
    // Save-back after exactly two ticks
    tval <= 32'h0000_0064;
    do_entry();
    repeat (70) step();
    do_exit(1, 32'h0000_0062, 32'h0000_0062);
    // Paging-off entry keeps the host long-mode enable, or loads the entry one when the load control is set
    act <= 1'b0;
    for (int h = 0; h < 4; h++) begin
      hlme <= h[0];
      elme <= !h[0];
      lext <= h[1];
      do_entry();
      note(12, h[0] ^ h[1], h[0] ^ h[1]);
      step();
      do_exit(0, 0, 0);
    end
    repeat (3) step();
    report_and_stop();
  end
endmodule : tb_veb_core
